// ==== pkg/pssr_pkg.sv ====
/*
 * Constants for the self status and 10 Mb/s status register bank:
 * register addresses, bit positions, strap decodes and frame lengths.
 * Assumes a management frame of preamble, start, opcode, two 5-bit
 * addresses, turnaround and 16 data bits.
 */
package pssr_pkg;
    // Register addresses on the management interface
    localparam logic [4:0] SELF_STATUS_ADDR = 5'h19;
    localparam logic [4:0] TEN_MEG_STATUS_ADDR = 5'h1b;

    // Self status bit positions
    localparam int SS_LOCK_BIT = 12;
    localparam int SS_CRS_SUP_BIT = 11;
    localparam int SS_AN_BIT = 10;
    localparam int SS_PAUSE_BIT = 9;
    localparam int SS_FAR_END_FAULT_MACHINES_EN_BIT = 8;
    localparam int SS_FDX_BIT = 7;
    localparam int SS_TEN_BIT = 6;
    localparam int SS_CIM_BIT = 5;
    localparam int SS_ADDR_MSB = 4;

    // 10 Mb/s status bit positions
    localparam int TM_POL_OK_BIT = 10;
    localparam int TM_SERIAL_BIT = 9;

    // Values after reset
    localparam logic RST_PAUSE = 1'b0;
    localparam logic RST_FAR_END_FAULT_MACHINES_EN = 1'b0;
    localparam logic RST_CIM = 1'b0;
    localparam logic RST_POL_OK = 1'b0;
    localparam logic RST_SERIAL = 1'b0;
    localparam logic RST_LOCK = 1'b0;

    // Autoneg strap decode
    localparam logic [1:0] AN_STRAP_AUTO = 2'h3;
    localparam int AN_STRAP_FDX_BIT = 0;

    // Frame layout
    localparam logic [5:0] PREAMBLE_MIN = 6'h20;
    localparam logic [4:0] HDR_LAST = 5'h0c;
    localparam logic [4:0] DATA_LAST = 5'h0f;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;

    // Frame states
    typedef enum logic [3:0] {
        ST_PRE = 4'h1,
        ST_HDR = 4'h2,
        ST_TA = 4'h4,
        ST_DATA = 4'h8
    } pssr_state_t;
endpackage : pssr_pkg

// ==== rtl/pssr_regs.sv ====
/*
 * Self status and 10 Mb/s status registers behind a management-frame
 * slave, plus the carrier suppression, far-end fault run enable and
 * serial mode select they control.
 * Assumes MDC, MDIO and strap pins are asynchronous; status inputs
 * come from logic on SYS_CLK. MDC must be well below SYS_CLK / 8.
 */
// Notes on behaviour
// R1 - Bit 11 set and descrambler timeout: CRS held low until sync returns; resets to not-repeater.
// R2 - Pause bit 9 set only when both ends advertised pause; resets 0.
// R3 - Far-end fault machines run only with bit 8 set and bit 10 clear.
// R4 - Bit 7 reports full duplex; reset from autoneg straps selecting full duplex.
// R5 - Carrier integrity bit 5 latches on unstable link unless disabled; read clears.
// R6 - Address straps captured at reset into bits 4:0; device answers that address.
// R7 - Management controller addresses frames with the strapped address.
// R8 - Polarity bit 10 high when receive polarity correct, low when reversed; resets 0.
// R9 - Polarity bit shows true incoming polarity regardless of correction disable.
// R10 - Serial bit 9 selects serial when 1, nibble when 0, only in 10 Mb/s.
// R11 - Serial bit is a mode choice between serial and nibble transfer.
// R12 - Lock bit 12 set while descrambler synchronised, else clear; resets 0.
// R13 - Reserved 10 Mb/s status bits read zero, writes ignored.
`timescale 1ns/1ns
`default_nettype none
module pssr_regs (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic SRST,
    // Management pins
    input wire logic MDC,
    input wire logic MDIO_IN,
    output logic MDIO_OUT,
    output logic MDIO_OE_N,
    // Straps
    input wire logic REPEATER_STRAP,
    input wire logic [1:0] AUTONEG_STRAP_PINS,
    input wire logic [4:0] MGMT_ADDRESS_STRAPS,
    // Status from the data path
    input wire logic DESCR_LOCK,
    input wire logic DESCR_TIMEOUT,
    input wire logic CRS_IN,
    input wire logic LOCAL_PAUSE_ADV,
    input wire logic PARTNER_PAUSE_ADV,
    input wire logic CIM_UNSTABLE,
    input wire logic CIM_DISABLE,
    input wire logic RX_POLARITY_OK,
    input wire logic TEN_MEG_MODE,
    // Controls to the data path
    output logic CRS_OUT,
    output logic FAR_END_FAULT_MACHINES_RUN,
    output logic SERIAL_MODE
);
    logic [9:0] pins_q;
    logic mdc_q, mdio_q, rep_q;
    logic [1:0] an_q;
    logic [4:0] addr_q;

    pssr_sync #(.WIDTH(10)) u_sync (
        .clk(SYS_CLK),
        .d({MDC, MDIO_IN, REPEATER_STRAP, AUTONEG_STRAP_PINS, MGMT_ADDRESS_STRAPS}),
        .q(pins_q)
    );
    assign mdc_q = pins_q[9];
    assign mdio_q = pins_q[8];
    assign rep_q = pins_q[7];
    assign an_q = pins_q[6:5];
    assign addr_q = pins_q[4:0];

    // Register fields
    logic lock_reg, crs_sup_reg, an_reg, pause_reg, far_end_fault_machines_en_reg, fdx_reg, ten_reg, cim_reg;
    logic [4:0] phy_addr_reg;
    logic pol_ok_reg, serial_reg, crs_hold_reg, crs_out_reg, far_end_fault_machines_run_reg, serial_mode_reg;

    // Frame engine
    pssr_pkg::pssr_state_t state_reg, state_next;
    logic mdc_d_reg;
    logic [5:0] ones_reg;
    logic [4:0] cnt_reg;
    logic [12:0] hdr_reg;
    logic [15:0] shift_reg;
    logic is_read_reg;
    logic [4:0] regad_reg;
    logic mdio_out_reg, mdio_oe_n_reg;

    wire mdc_rise = mdc_q & ~mdc_d_reg;
    wire [12:0] hdr_next = {hdr_reg[11:0], mdio_q};
    wire hdr_done = mdc_rise && state_reg == pssr_pkg::ST_HDR && cnt_reg == pssr_pkg::HDR_LAST;
    wire [1:0] hdr_op = hdr_next[11:10];
    wire hdr_ok = hdr_next[12] && hdr_next[9:5] == phy_addr_reg // R6
                  && (hdr_op == pssr_pkg::OP_READ || hdr_op == pssr_pkg::OP_WRITE);
    wire data_done = mdc_rise && state_reg == pssr_pkg::ST_DATA && cnt_reg == pssr_pkg::DATA_LAST;
    wire [15:0] wr_data = {shift_reg[14:0], mdio_q};
    wire wr_self = data_done && !is_read_reg && regad_reg == pssr_pkg::SELF_STATUS_ADDR;
    wire wr_ten = data_done && !is_read_reg && regad_reg == pssr_pkg::TEN_MEG_STATUS_ADDR;
    wire ta_first = mdc_rise && state_reg == pssr_pkg::ST_TA && cnt_reg == 5'h0;
    wire rd_self = ta_first && is_read_reg && regad_reg == pssr_pkg::SELF_STATUS_ADDR;
    wire rd_mapped = regad_reg == pssr_pkg::SELF_STATUS_ADDR || regad_reg == pssr_pkg::TEN_MEG_STATUS_ADDR;

    wire [15:0] self_rd = {3'h0, lock_reg, crs_sup_reg, an_reg, pause_reg, far_end_fault_machines_en_reg,
                           fdx_reg, ten_reg, cim_reg, phy_addr_reg};
    wire [15:0] ten_rd = {5'h00, pol_ok_reg, serial_reg, 9'h000}; // R13
    wire [15:0] rd_data = (regad_reg == pssr_pkg::SELF_STATUS_ADDR) ? self_rd : ten_rd;

    wire cim_set = CIM_UNSTABLE & ~CIM_DISABLE;
    wire an_strap_auto = an_q == pssr_pkg::AN_STRAP_AUTO;

    always_comb begin
        state_next = state_reg;
        if (mdc_rise) begin
            unique case (state_reg)
                pssr_pkg::ST_PRE: begin
                    if (!mdio_q && ones_reg >= pssr_pkg::PREAMBLE_MIN) begin
                        state_next = pssr_pkg::ST_HDR;
                    end
                end
                pssr_pkg::ST_HDR: begin
                    if (cnt_reg == pssr_pkg::HDR_LAST) begin
                        state_next = hdr_ok ? pssr_pkg::ST_TA : pssr_pkg::ST_PRE;
                    end
                end
                pssr_pkg::ST_TA: begin
                    if (cnt_reg != 5'h0) begin
                        state_next = pssr_pkg::ST_DATA;
                    end
                end
                pssr_pkg::ST_DATA: begin
                    if (cnt_reg == pssr_pkg::DATA_LAST) begin
                        state_next = pssr_pkg::ST_PRE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            state_reg <= pssr_pkg::ST_PRE;
            mdc_d_reg <= 1'b0;
            ones_reg <= 6'h00;
            cnt_reg <= 5'h00;
            hdr_reg <= 13'h0000;
            shift_reg <= 16'h0000;
            is_read_reg <= 1'b0;
            regad_reg <= 5'h00;
            mdio_out_reg <= 1'b1;
            mdio_oe_n_reg <= 1'b1;
        end else begin
            mdc_d_reg <= mdc_q;
            state_reg <= state_next;
            if (mdc_rise) begin
                unique case (state_reg)
                    pssr_pkg::ST_PRE: begin
                        ones_reg <= !mdio_q ? 6'h00 :
                            (ones_reg >= pssr_pkg::PREAMBLE_MIN ? ones_reg : ones_reg + 6'h01);
                        cnt_reg <= 5'h00;
                    end
                    pssr_pkg::ST_HDR: begin
                        hdr_reg <= hdr_next;
                        cnt_reg <= cnt_reg + 5'h01;
                        ones_reg <= 6'h00;
                        if (hdr_done) begin
                            cnt_reg <= 5'h00;
                            is_read_reg <= hdr_op == pssr_pkg::OP_READ;
                            regad_reg <= hdr_next[4:0];
                        end
                    end
                    pssr_pkg::ST_TA: begin
                        cnt_reg <= cnt_reg + 5'h01;
                        if (cnt_reg == 5'h0) begin
                            shift_reg <= rd_data;
                            mdio_out_reg <= 1'b0;
                            mdio_oe_n_reg <= ~(is_read_reg & rd_mapped);
                        end else begin
                            cnt_reg <= 5'h00;
                            mdio_out_reg <= shift_reg[15];
                            shift_reg <= {shift_reg[14:0], 1'b0};
                        end
                    end
                    pssr_pkg::ST_DATA: begin
                        cnt_reg <= cnt_reg + 5'h01;
                        shift_reg <= is_read_reg ? {shift_reg[14:0], 1'b0} : wr_data;
                        mdio_out_reg <= shift_reg[15];
                        if (data_done) begin
                            mdio_out_reg <= 1'b1;
                            mdio_oe_n_reg <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    assign MDIO_OUT = mdio_out_reg;
    assign MDIO_OE_N = mdio_oe_n_reg;

    // Register bank; straps sampled every reset cycle, hold SRST long enough
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            lock_reg <= pssr_pkg::RST_LOCK;
            crs_sup_reg <= ~rep_q; // R1
            an_reg <= an_strap_auto;
            pause_reg <= pssr_pkg::RST_PAUSE;
            far_end_fault_machines_en_reg <= pssr_pkg::RST_FAR_END_FAULT_MACHINES_EN;
            fdx_reg <= an_q[pssr_pkg::AN_STRAP_FDX_BIT]; // R4
            ten_reg <= 1'b0;
            cim_reg <= pssr_pkg::RST_CIM;
            phy_addr_reg <= addr_q; // R6
            pol_ok_reg <= pssr_pkg::RST_POL_OK;
            serial_reg <= pssr_pkg::RST_SERIAL;
        end else begin
            lock_reg <= DESCR_LOCK; // R12
            pause_reg <= LOCAL_PAUSE_ADV & PARTNER_PAUSE_ADV; // R2
            ten_reg <= TEN_MEG_MODE;
            pol_ok_reg <= RX_POLARITY_OK; // R8 R9
            // Set wins over the read clear so no unstable event is lost
            cim_reg <= cim_set | (cim_reg & ~rd_self); // R5
            if (wr_self) begin
                crs_sup_reg <= wr_data[pssr_pkg::SS_CRS_SUP_BIT];
                far_end_fault_machines_en_reg <= wr_data[pssr_pkg::SS_FAR_END_FAULT_MACHINES_EN_BIT];
                phy_addr_reg <= wr_data[pssr_pkg::SS_ADDR_MSB:0];
            end
            if (wr_ten) begin
                serial_reg <= wr_data[pssr_pkg::TM_SERIAL_BIT]; // R13
            end
        end
    end

    // Data path controls
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            crs_hold_reg <= 1'b0;
            crs_out_reg <= 1'b0;
            far_end_fault_machines_run_reg <= 1'b0;
            serial_mode_reg <= 1'b0;
        end else begin
            if (DESCR_LOCK) begin
                crs_hold_reg <= 1'b0;
            end else if (DESCR_TIMEOUT && crs_sup_reg) begin
                crs_hold_reg <= 1'b1;
            end
            crs_out_reg <= CRS_IN & ~crs_hold_reg & ~(DESCR_TIMEOUT & crs_sup_reg); // R1
            far_end_fault_machines_run_reg <= far_end_fault_machines_en_reg & ~an_reg; // R3
            serial_mode_reg <= ten_reg & serial_reg; // R10 R11
        end
    end

    assign CRS_OUT = crs_out_reg;
    assign FAR_END_FAULT_MACHINES_RUN = far_end_fault_machines_run_reg;
    assign SERIAL_MODE = serial_mode_reg;
endmodule // pssr_regs
`default_nettype wire

// ==== rtl/pssr_sync.sv ====
/*
 * Three-flop input synchroniser with agreement filter.
 * Assumes inputs are asynchronous to clk; output follows once the
 * second and third stages agree.
 */
`timescale 1ns/1ns
`default_nettype none
module pssr_sync #(
    parameter int WIDTH = 1
) (
    // Clock
    input wire logic clk,
    // Asynchronous in, filtered out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] agree;

    // No reset: straps must flow through while reset is held
    assign agree = ~(s2_reg ^ s3_reg);
    assign q = q_reg;

    always_ff @(posedge clk) begin
        s1_reg <= d;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        q_reg <= (agree & s2_reg) | (~agree & q_reg);
    end
endmodule // pssr_sync
`default_nettype wire

// ==== tb/pssr_mdio_master.sv ====
/* Management controller model: preamble, header, turnaround, data.
   Assumes a pull-up on the data line; each MDC half-period spans 10 clocks. */
`timescale 1ns/1ns
`default_nettype none
module pssr_mdio_master (
    // Clock
    input wire logic clk,
    // Management pins
    input wire logic mdio,
    output logic mdc,
    output logic mdio_drv
);
    initial begin
        mdc = 1'b0;
        mdio_drv = 1'b1;
    end
    // Sample late in the high phase, after the device output settles
    task automatic bit_io(input logic b, output logic s);
        mdio_drv = b;
        repeat (10) @(negedge clk);
        mdc = 1'b1;
        repeat (10) @(negedge clk);
        s = mdio;
        mdc = 1'b0;
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                         input logic [15:0] wd, output logic [15:0] rd, output logic ta);
        logic s;
        logic [13:0] hdr;
        hdr = {2'h1, op, phy, rg};
        for (int i = 0; i < 32; i++) bit_io(1'b1, s);
        for (int i = 13; i >= 0; i--) bit_io(hdr[i], s);
        bit_io(1'b1, ta);
        bit_io(!op[0], rd[15]);
        for (int i = 14; i >= 0; i--) bit_io(op[0] ? wd[i+1] : 1'b1, rd[i]);
        bit_io(op[0] ? wd[0] : 1'b1, s);
        bit_io(1'b1, s);
    endtask
endmodule // pssr_mdio_master
`default_nettype wire

// ==== tb/pssr_regs_assertions.sv ====
/* Port checker for the status register bank.
   Assumes straps change only while SRST is high. */
`timescale 1ns/1ns
`default_nettype none
module pssr_regs_assertions (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic SRST,
    // Watched pins
    input wire logic MDIO_OUT,
    input wire logic MDIO_OE_N,
    input wire logic [1:0] AUTONEG_STRAP_PINS,
    input wire logic DESCR_LOCK,
    input wire logic CRS_IN,
    input wire logic TEN_MEG_MODE,
    input wire logic CRS_OUT,
    input wire logic FAR_END_FAULT_MACHINES_RUN,
    input wire logic SERIAL_MODE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    a_crs_never_above: assert property (CRS_OUT |-> $past(CRS_IN))
        else $error("carrier out high without carrier in");
    a_crs_lock_pass: assert property (DESCR_LOCK [*3] |-> CRS_OUT == $past(CRS_IN))
        else $error("carrier held while descrambler locked");
    a_far_end_fault_machines_auto_off: assert property (AUTONEG_STRAP_PINS == 2'h3 |-> !FAR_END_FAULT_MACHINES_RUN)
        else $error("far-end fault machines run with autoneg on");
    a_serial_needs_ten: assert property (SERIAL_MODE |-> $past(TEN_MEG_MODE, 2))
        else $error("serial mode outside 10 Mb/s");
    a_serial_off_fast: assert property (!TEN_MEG_MODE [*3] |-> !SERIAL_MODE)
        else $error("serial mode lingers");
    a_ta_drives_zero: assert property ($fell(MDIO_OE_N) |-> !MDIO_OUT)
        else $error("turnaround bit not zero");
    a_drive_holds: assert property ($fell(MDIO_OE_N) |=> !MDIO_OE_N [*8])
        else $error("read drive released early");
    a_reset_idle: assert property (disable iff (1'b0)
        SRST |=> MDIO_OE_N && MDIO_OUT && !CRS_OUT && !SERIAL_MODE && !FAR_END_FAULT_MACHINES_RUN)
        else $error("outputs not idle in reset");
endmodule // pssr_regs_assertions
`default_nettype wire

// ==== tb/testbench.sv ====
/* Top bench: master model, design and checker.
   Assumes the design answers only its strapped address. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic rep = 1'b0;
    logic [1:0] an = 2'h1;
    logic [4:0] pa = 5'h0a;
    logic lock = 1'b1, tmo = 1'b0, crs = 1'b1, lp = 1'b1, pp = 1'b1;
    logic cu = 1'b0, cd = 1'b0, pol = 1'b1, ten = 1'b1;
    wire mdc, mdrv, mout, moe_n, crs_o, run, ser;
    wire mdio = !moe_n ? mout : mdrv;
    int errors = 0, n_compared = 0;
    logic [15:0] rd;
    logic ta;
    localparam logic [4:0] SS = pssr_pkg::SELF_STATUS_ADDR;
    localparam logic [4:0] TM = pssr_pkg::TEN_MEG_STATUS_ADDR;
    always #20 clk = ~clk;
    pssr_mdio_master i_mst (.clk(clk), .mdio(mdio), .mdc(mdc), .mdio_drv(mdrv));
    pssr_regs i_dut (.SYS_CLK(clk), .SRST(srst), .MDC(mdc), .MDIO_IN(mdio), .MDIO_OUT(mout),
        .MDIO_OE_N(moe_n), .REPEATER_STRAP(rep), .AUTONEG_STRAP_PINS(an), .MGMT_ADDRESS_STRAPS(pa),
        .DESCR_LOCK(lock), .DESCR_TIMEOUT(tmo), .CRS_IN(crs), .LOCAL_PAUSE_ADV(lp),
        .PARTNER_PAUSE_ADV(pp), .CIM_UNSTABLE(cu), .CIM_DISABLE(cd), .RX_POLARITY_OK(pol),
        .TEN_MEG_MODE(ten), .CRS_OUT(crs_o), .FAR_END_FAULT_MACHINES_RUN(run), .SERIAL_MODE(ser));
    task automatic chk(input logic [16:0] s, input logic [16:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Answered read: turnaround zero, then the word
    task automatic rdreg(input logic [4:0] r, input logic [15:0] e);
        i_mst.frame(pssr_pkg::OP_READ, pa, r, 16'h0000, rd, ta);
        chk({ta, rd}, {1'b0, e});
    endtask
    task automatic wrreg(input logic [4:0] r, input logic [15:0] d);
        i_mst.frame(pssr_pkg::OP_WRITE, pa, r, d, rd, ta);
        tick(3);
    endtask
    task automatic pulse_cim;
        cu = 1'b1;
        tick(1);
        cu = 1'b0;
    endtask
    task automatic rst(input logic rp, input logic [1:0] a, input logic [4:0] p);
        srst = 1'b1;
        rep = rp;
        an = a;
        pa = p;
        tick(5);
        srst = 1'b0;
        tick(4);
    endtask
    task automatic final_report;
        $display("compared=%0d errors=%0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        rst(1'b0, 2'h1, 5'h0a);
        rdreg(SS, 16'h1aca);
        rdreg(TM, 16'h0400);
        wrreg(TM, 16'hffff);
        pol = 1'b0;
        rdreg(TM, 16'h0200);
        chk({16'h0, ser}, 17'h1);
        ten = 1'b0;
        tick(3);
        chk({16'h0, ser}, 17'h0);
        pp = 1'b0;
        pulse_cim;
        rdreg(SS, 16'h18aa);
        rdreg(SS, 16'h188a);
        cd = 1'b1;
        pulse_cim;
        rdreg(SS, 16'h188a);
        wrreg(SS, 16'h010a);
        chk({16'h0, run}, 17'h1);
        lock = 1'b0;
        tmo = 1'b1;
        tick(3);
        chk({16'h0, crs_o}, 17'h1);
        wrreg(SS, 16'h090a);
        tick(3);
        chk({16'h0, crs_o}, 17'h0);
        tmo = 1'b0;
        lock = 1'b1;
        tick(3);
        chk({16'h0, crs_o}, 17'h1);
        i_mst.frame(pssr_pkg::OP_READ, 5'h15, SS, 16'h0000, rd, ta);
        chk({ta, rd}, 17'h1ffff);
        i_mst.frame(pssr_pkg::OP_READ, pa, 5'h1c, 16'h0000, rd, ta);
        chk({ta, rd}, 17'h1ffff);
        rst(1'b1, 2'h3, 5'h15);
        rdreg(SS, 16'h1495);
        rdreg(TM, 16'h0000);
        wrreg(SS, 16'h0115);
        chk({16'h0, run}, 17'h0);
        rdreg(SS, 16'h1595);
        rst(1'b0, 2'h2, 5'h15);
        rdreg(SS, 16'h1815);
        final_report;
    end
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        final_report;
    end
endmodule // testbench
bind pssr_regs pssr_regs_assertions i_chk (.SYS_CLK(SYS_CLK), .SRST(SRST), .MDIO_OUT(MDIO_OUT),
    .MDIO_OE_N(MDIO_OE_N), .AUTONEG_STRAP_PINS(AUTONEG_STRAP_PINS), .DESCR_LOCK(DESCR_LOCK),
    .CRS_IN(CRS_IN), .TEN_MEG_MODE(TEN_MEG_MODE), .CRS_OUT(CRS_OUT),
    .FAR_END_FAULT_MACHINES_RUN(FAR_END_FAULT_MACHINES_RUN), .SERIAL_MODE(SERIAL_MODE));
`default_nettype wire
